// ==== design/hpvr_pkg.sv ====
// Constants shared by the host port VLAN and rate control block
`default_nettype none
package hpvr_pkg;
  // ==========================================================
  // Bus and register map
  localparam int HPVR_AW = 8;
  localparam int HPVR_DW = 16;
  localparam logic [HPVR_AW-1:0] HPVR_OFF_TAG = 8'ha0;
  localparam logic [HPVR_AW-1:0] HPVR_OFF_MODE = 8'ha2;
  localparam logic [HPVR_AW-1:0] HPVR_OFF_IRLO = 8'ha4;
  localparam logic [HPVR_AW-1:0] HPVR_OFF_IRHI = 8'ha6;
  localparam logic [HPVR_AW-1:0] HPVR_OFF_ERLO = 8'ha8;
  localparam logic [HPVR_AW-1:0] HPVR_OFF_ERHI = 8'haa;
  localparam logic [HPVR_AW-1:0] HPVR_OFF_QCFG = 8'hb0;
  localparam logic [HPVR_AW-1:0] HPVR_OFF_STAT = 8'hb2;
  // ==========================================================
  // Field layout
  localparam int HPVR_VID_W = 12;
  localparam int HPVR_CFI_BIT = 12;
  localparam int HPVR_UPRI_LSB = 13;
  localparam int HPVR_UPRI_W = 3;
  localparam int HPVR_MACMODE_BIT = 7;
  localparam int HPVR_ILM_LSB = 2;
  localparam int HPVR_IFG_BIT = 1;
  localparam int HPVR_PRE_BIT = 0;
  localparam int HPVR_RATE_W = 7;
  localparam int HPVR_RATE_HI_LSB = 8;
  localparam int HPVR_RATE_LO_LSB = 0;
  localparam int HPVR_EDGE_BIT = 7;
  localparam int HPVR_EGEN_BIT = 7;
  localparam int HPVR_QMULTI_BIT = 0;
  localparam int HPVR_QTWO_BIT = 1;
  localparam int HPVR_MODE_W = 8;
  localparam int HPVR_CNT_W = 8;
  // ==========================================================
  // Reset values and write masks
  localparam logic [HPVR_DW-1:0] HPVR_TAG_RST = 16'h0001;
  localparam logic [HPVR_DW-1:0] HPVR_ZERO_RST = 16'h0000;
  localparam logic [HPVR_DW-1:0] HPVR_MASK_RLO = 16'h7fff;
  localparam logic [HPVR_DW-1:0] HPVR_MASK_RHI = 16'h7f7f;
  localparam logic [HPVR_DW-1:0] HPVR_MASK_QCFG = 16'h0003;
  // ==========================================================
  // Metering
  localparam int HPVR_LEN_W = 11;
  localparam int HPVR_CHG_W = 12;
  localparam int HPVR_BKT_W = 16;
  localparam int HPVR_PRIOS = 4;
  localparam int HPVR_CODES = 128;
  localparam logic [HPVR_CHG_W-1:0] HPVR_IFG_BYTES = 12'h00c;
  localparam logic [HPVR_CHG_W-1:0] HPVR_PRE_BYTES = 12'h008;
  localparam logic [HPVR_RATE_W-1:0] HPVR_RATE_FULL = 7'h00;
  localparam int HPVR_CLK_MHZ = 50;
  localparam int HPVR_WINDOW_US = 1000;
  localparam int HPVR_WINDOW_CYC = HPVR_WINDOW_US * HPVR_CLK_MHZ;
  localparam int HPVR_BYTES_PER_CODE = 98;

  typedef enum logic [1:0] {
    HPVR_ILM_ALL = 2'b00,
    HPVR_ILM_BMF = 2'b01,
    HPVR_ILM_BM = 2'b10,
    HPVR_ILM_B = 2'b11
  } hpvr_ilm_e;

  typedef logic [HPVR_CODES*HPVR_BKT_W-1:0] hpvr_table_t;

  // Linear default: each code step allows a fixed byte count per window
  function automatic hpvr_table_t hpvrBuildTable(input int step);
    hpvr_table_t t;
    t = '0;
    for (int i = 0; i < HPVR_CODES; i++) begin
      t[i*HPVR_BKT_W +: HPVR_BKT_W] = HPVR_BKT_W'(i * step);
    end
    return t;
  endfunction : hpvrBuildTable
endpackage : hpvr_pkg
`default_nettype wire

// ==== design/hpvr_host_port_ctrl.sv ====
// Host port default tag, mode strap and ingress/egress rate limiter
//
// Functional notes
// - 12-bit default VID, resets to one
// - Priority bits 15:13, CFI bit 12, reset zero
// - Receive-valid strap latched into mode bit 7
// - Ingress limit mode selects metered frame classes
// - Gap bit adds twelve bytes per frame
// - Preamble bit adds eight bytes per frame
// - Ingress priorities 1 and 0 limits
// - Ingress priorities 3 and 2 limits
// - Code zero means full rate, no limit
// - Bit 7 picks RMII sample edge
// - Single queue applies priority-0 egress limit only
// - Two queues apply priority-1 and priority-0 limits
// - Egress limiting only while enable bit set
// - Egress priorities 1 and 0 limit fields
// - Multi-queue bit splits output into four queues, or two when the two-queue bit is also set
//
// The strobed register port was chosen for this implementation.
`default_nettype none
module hpvr_host_port_ctrl #(
  parameter int WINDOW_CYC = hpvr_pkg::HPVR_WINDOW_CYC,
  parameter hpvr_pkg::hpvr_table_t RATE_TABLE =
    hpvr_pkg::hpvrBuildTable(hpvr_pkg::HPVR_BYTES_PER_CODE)
) (
  input wire logic clock,
  input wire logic srst,
  input wire logic [hpvr_pkg::HPVR_AW-1:0] regAddr,
  input wire logic [hpvr_pkg::HPVR_DW-1:0] regWrData,
  input wire logic regWrite,
  input wire logic regRead,
  output logic [hpvr_pkg::HPVR_DW-1:0] regRdData_q,
  input wire logic rxDataValidPin,
  input wire logic igFrame,
  input wire logic [hpvr_pkg::HPVR_LEN_W-1:0] igLength,
  input wire logic [1:0] igPriority,
  input wire logic igBroadcast,
  input wire logic igMulticast,
  input wire logic igFloodUnicast,
  output logic igDone_q,
  output logic igDrop_q,
  input wire logic egFrame,
  input wire logic [hpvr_pkg::HPVR_LEN_W-1:0] egLength,
  input wire logic [1:0] egPriority,
  output logic egDone_q,
  output logic egAllow_q,
  output logic [1:0] egQueue_q,
  output logic [hpvr_pkg::HPVR_VID_W-1:0] defaultVid_q,
  output logic [hpvr_pkg::HPVR_UPRI_W-1:0] defaultPriority_q,
  output logic defaultCfi_q,
  output logic macMiiMode_q,
  output logic rmiiSampleFalling_q,
  output logic multiQueue_q
);
  import hpvr_pkg::*;

  // ==========================================================
  // Register storage
  logic [HPVR_DW-1:0] tagReg_q;
  logic [HPVR_MODE_W-1:0] modeReg_q;
  logic [HPVR_DW-1:0] irLoReg_q;
  logic [HPVR_DW-1:0] irHiReg_q;
  logic [HPVR_DW-1:0] erLoReg_q;
  logic [HPVR_DW-1:0] erHiReg_q;
  logic [HPVR_DW-1:0] qCfgReg_q;
  logic [HPVR_CNT_W-1:0] igDropCnt_q;
  logic [HPVR_CNT_W-1:0] egDenyCnt_q;
  logic strapPending_q;
  logic strapMeta_q;
  logic strapSync_q;

  // The pin is asynchronous; two stages before the capture reads it
  always_ff @(posedge clock) begin
    strapMeta_q <= rxDataValidPin;
    strapSync_q <= strapMeta_q;
  end

  always_ff @(posedge clock) begin
    if (srst) begin
      tagReg_q <= HPVR_TAG_RST;
    end else if (regWrite && regAddr == HPVR_OFF_TAG) begin
      tagReg_q <= regWrData;
    end
  end

  // ==========================================================
  // Strap capture
  // Strap is caught in the first cycle after release, then software owns it
  always_ff @(posedge clock) begin
    if (srst) begin
      strapPending_q <= 1'b1;
      modeReg_q <= HPVR_ZERO_RST[HPVR_MODE_W-1:0];
    end else if (strapPending_q) begin
      strapPending_q <= 1'b0;
      modeReg_q[HPVR_MACMODE_BIT] <= strapSync_q;
    end else if (regWrite && regAddr == HPVR_OFF_MODE) begin
      modeReg_q <= regWrData[HPVR_MODE_W-1:0];
    end
  end

  // ==========================================================
  // Rate limit registers
  // Ingress limits; bit 7 of the low register also selects the RMII sample edge
  always_ff @(posedge clock) begin
    if (srst) begin
      irLoReg_q <= HPVR_ZERO_RST;
      irHiReg_q <= HPVR_ZERO_RST;
    end else if (regWrite) begin
      if (regAddr == HPVR_OFF_IRLO) begin
        irLoReg_q <= regWrData & HPVR_MASK_RLO;
      end
      if (regAddr == HPVR_OFF_IRHI) begin
        irHiReg_q <= regWrData & HPVR_MASK_RHI;
      end
    end
  end

  // Egress limits; bit 7 of the low register is the limit enable
  always_ff @(posedge clock) begin
    if (srst) begin
      erLoReg_q <= HPVR_ZERO_RST;
      erHiReg_q <= HPVR_ZERO_RST;
    end else if (regWrite) begin
      if (regAddr == HPVR_OFF_ERLO) begin
        erLoReg_q <= regWrData & HPVR_MASK_RLO;
      end
      if (regAddr == HPVR_OFF_ERHI) begin
        erHiReg_q <= regWrData & HPVR_MASK_RHI;
      end
    end
  end

  // ==========================================================
  // Queue layout
  always_ff @(posedge clock) begin
    if (srst) begin
      qCfgReg_q <= HPVR_ZERO_RST;
    end else if (regWrite && regAddr == HPVR_OFF_QCFG) begin
      qCfgReg_q <= regWrData & HPVR_MASK_QCFG;
    end
  end

  // ==========================================================
  // Read port
  always_ff @(posedge clock) begin
    if (srst) begin
      regRdData_q <= HPVR_ZERO_RST;
    end else if (regRead) begin
      unique case (regAddr)
        HPVR_OFF_TAG: regRdData_q <= tagReg_q;
        HPVR_OFF_MODE: regRdData_q <= {{(HPVR_DW-HPVR_MODE_W){1'b0}}, modeReg_q};
        HPVR_OFF_IRLO: regRdData_q <= irLoReg_q;
        HPVR_OFF_IRHI: regRdData_q <= irHiReg_q;
        HPVR_OFF_ERLO: regRdData_q <= erLoReg_q;
        HPVR_OFF_ERHI: regRdData_q <= erHiReg_q;
        HPVR_OFF_QCFG: regRdData_q <= qCfgReg_q;
        HPVR_OFF_STAT: regRdData_q <= {egDenyCnt_q, igDropCnt_q};
        default: regRdData_q <= HPVR_ZERO_RST;
      endcase
    end
  end

  // ==========================================================
  // Configuration outputs
  // Copies are registered so every port comes from a flop; they trail by a cycle
  always_ff @(posedge clock) begin
    if (srst) begin
      defaultVid_q <= HPVR_TAG_RST[HPVR_VID_W-1:0];
      defaultPriority_q <= '0;
      defaultCfi_q <= 1'b0;
      macMiiMode_q <= 1'b0;
      rmiiSampleFalling_q <= 1'b0;
      multiQueue_q <= 1'b0;
    end else begin
      defaultVid_q <= tagReg_q[HPVR_VID_W-1:0];
      defaultPriority_q <= tagReg_q[HPVR_UPRI_LSB +: HPVR_UPRI_W];
      defaultCfi_q <= tagReg_q[HPVR_CFI_BIT];
      macMiiMode_q <= modeReg_q[HPVR_MACMODE_BIT];
      rmiiSampleFalling_q <= irLoReg_q[HPVR_EDGE_BIT];
      multiQueue_q <= qCfgReg_q[HPVR_QMULTI_BIT];
    end
  end

  // ==========================================================
  // Metering window
  // One window shared by all buckets; the wide count covers any window length
  logic [31:0] winCnt_q;
  logic winTick;

  assign winTick = (winCnt_q == 32'(WINDOW_CYC - 1));

  always_ff @(posedge clock) begin
    if (srst || winTick) begin
      winCnt_q <= '0;
    end else begin
      winCnt_q <= winCnt_q + 32'h0000_0001;
    end
  end

  function automatic logic [HPVR_BKT_W-1:0] rateBytes(input logic [HPVR_RATE_W-1:0] code);
    return RATE_TABLE[code*HPVR_BKT_W +: HPVR_BKT_W];
  endfunction : rateBytes

  // ==========================================================
  // Per-frame charge and limit selection
  logic [HPVR_CHG_W-1:0] overhead;
  logic [HPVR_CHG_W-1:0] igCharge;
  logic [HPVR_CHG_W-1:0] egCharge;
  logic [HPVR_RATE_W-1:0] igCode [HPVR_PRIOS];
  logic [HPVR_RATE_W-1:0] egCode [HPVR_PRIOS];
  logic igMetered;
  logic [1:0] egQueue;

  // Gap and preamble bytes are charged alike in both directions
  always_comb begin
    overhead = '0;
    if (modeReg_q[HPVR_IFG_BIT]) begin
      overhead = overhead + HPVR_IFG_BYTES;
    end
    if (modeReg_q[HPVR_PRE_BIT]) begin
      overhead = overhead + HPVR_PRE_BYTES;
    end
  end

  assign igCharge = HPVR_CHG_W'(igLength) + overhead;
  assign egCharge = HPVR_CHG_W'(egLength) + overhead;

  assign igCode[0] = irLoReg_q[HPVR_RATE_LO_LSB +: HPVR_RATE_W];
  assign igCode[1] = irLoReg_q[HPVR_RATE_HI_LSB +: HPVR_RATE_W];
  assign igCode[2] = irHiReg_q[HPVR_RATE_LO_LSB +: HPVR_RATE_W];
  assign igCode[3] = irHiReg_q[HPVR_RATE_HI_LSB +: HPVR_RATE_W];
  assign egCode[0] = erLoReg_q[HPVR_RATE_LO_LSB +: HPVR_RATE_W];
  assign egCode[1] = erLoReg_q[HPVR_RATE_HI_LSB +: HPVR_RATE_W];
  assign egCode[2] = erHiReg_q[HPVR_RATE_LO_LSB +: HPVR_RATE_W];
  assign egCode[3] = erHiReg_q[HPVR_RATE_HI_LSB +: HPVR_RATE_W];

  // Unmetered classes bypass the buckets and are never charged
  always_comb begin
    unique case (hpvr_ilm_e'(modeReg_q[HPVR_ILM_LSB +: 2]))
      HPVR_ILM_ALL: igMetered = 1'b1;
      HPVR_ILM_BMF: igMetered = igBroadcast | igMulticast | igFloodUnicast;
      HPVR_ILM_BM: igMetered = igBroadcast | igMulticast;
      HPVR_ILM_B: igMetered = igBroadcast;
    endcase
  end

  // Queue count decides which egress limits are live
  // In two-queue mode priorities 1 to 3 share queue 1, priority 0 keeps queue 0
  always_comb begin
    if (!qCfgReg_q[HPVR_QMULTI_BIT]) begin
      egQueue = 2'b00;
    end else if (qCfgReg_q[HPVR_QTWO_BIT]) begin
      egQueue = {1'b0, egPriority != 2'b00};
    end else begin
      egQueue = egPriority;
    end
  end

  // ==========================================================
  // Byte buckets, one per priority and direction
  logic [HPVR_BKT_W-1:0] igUsed_q [HPVR_PRIOS];
  logic [HPVR_BKT_W-1:0] egUsed_q [HPVR_PRIOS];
  logic [HPVR_PRIOS-1:0] igOver;
  logic [HPVR_PRIOS-1:0] egOver;
  logic igPass;
  logic egPass;

  // Code zero never limits; a frame that would overflow the window is refused
  assign igPass = !igMetered || !igOver[igPriority];
  assign egPass = !erLoReg_q[HPVR_EGEN_BIT] || !egOver[egQueue];

  for (genvar p = 0; p < HPVR_PRIOS; p++) begin : g_bucket
    logic [HPVR_BKT_W-1:0] igBase;
    logic [HPVR_BKT_W-1:0] egBase;
    logic [HPVR_BKT_W:0] igSum;
    logic [HPVR_BKT_W:0] egSum;

    // A frame on the window edge opens the new window instead of being lost
    assign igBase = winTick ? '0 : igUsed_q[p];
    assign egBase = winTick ? '0 : egUsed_q[p];
    assign igSum = {1'b0, igBase} + (HPVR_BKT_W+1)'(igCharge);
    assign egSum = {1'b0, egBase} + (HPVR_BKT_W+1)'(egCharge);
    assign igOver[p] = igCode[p] != HPVR_RATE_FULL &&
                       igSum > (HPVR_BKT_W+1)'(rateBytes(igCode[p]));
    assign egOver[p] = egCode[p] != HPVR_RATE_FULL &&
                       egSum > (HPVR_BKT_W+1)'(rateBytes(egCode[p]));

    // Only code zero can run past the top; saturate so a later limit sees a full bucket
    always_ff @(posedge clock) begin
      if (srst) begin
        igUsed_q[p] <= '0;
      end else if (igFrame && igMetered && igPass && igPriority == 2'(p)) begin
        igUsed_q[p] <= igSum[HPVR_BKT_W] ? '1 : igSum[HPVR_BKT_W-1:0];
      end else if (winTick) begin
        igUsed_q[p] <= '0;
      end
    end

    always_ff @(posedge clock) begin
      if (srst) begin
        egUsed_q[p] <= '0;
      end else if (egFrame && erLoReg_q[HPVR_EGEN_BIT] && egPass && egQueue == 2'(p)) begin
        egUsed_q[p] <= egSum[HPVR_BKT_W] ? '1 : egSum[HPVR_BKT_W-1:0];
      end else if (winTick) begin
        egUsed_q[p] <= '0;
      end
    end
  end

  // ==========================================================
  // Decisions and statistics
  // Drop and deny counters stop at all ones so a long burst never reads as few
  always_ff @(posedge clock) begin
    if (srst) begin
      igDone_q <= 1'b0;
      igDrop_q <= 1'b0;
      igDropCnt_q <= '0;
    end else begin
      igDone_q <= igFrame;
      igDrop_q <= igFrame && !igPass;
      if (igFrame && !igPass && igDropCnt_q != '1) begin
        igDropCnt_q <= igDropCnt_q + 8'h01;
      end
    end
  end

  always_ff @(posedge clock) begin
    if (srst) begin
      egDone_q <= 1'b0;
      egAllow_q <= 1'b0;
      egQueue_q <= 2'b00;
      egDenyCnt_q <= '0;
    end else begin
      egDone_q <= egFrame;
      egAllow_q <= egFrame && egPass;
      egQueue_q <= egFrame ? egQueue : egQueue_q;
      if (egFrame && !egPass && egDenyCnt_q != '1) begin
        egDenyCnt_q <= egDenyCnt_q + 8'h01;
      end
    end
  end
endmodule : hpvr_host_port_ctrl
`default_nettype wire

// ==== verification/hpvr_checker.sv ====
// Concurrent checks on the host port control block ports
`default_nettype none
module hpvr_checker (
  input wire logic clock,
  input wire logic srst,
  input wire logic [hpvr_pkg::HPVR_AW-1:0] regAddr,
  input wire logic [hpvr_pkg::HPVR_DW-1:0] regWrData,
  input wire logic regWrite,
  input wire logic rxDataValidPin,
  input wire logic igFrame,
  input wire logic igDone_q,
  input wire logic egFrame,
  input wire logic egDone_q,
  input wire logic [1:0] egQueue_q,
  input wire logic [hpvr_pkg::HPVR_VID_W-1:0] defaultVid_q,
  input wire logic [hpvr_pkg::HPVR_UPRI_W-1:0] defaultPriority_q,
  input wire logic defaultCfi_q,
  input wire logic macMiiMode_q,
  input wire logic rmiiSampleFalling_q,
  input wire logic multiQueue_q
);
  timeunit 1ns;
  timeprecision 1ns;
  import hpvr_pkg::*;
  // ==========================================================
  // Clocking and sequences
  default clocking cb @(posedge clock); endclocking
  default disable iff (srst);
  // Field copies lag the register by one cycle, so they show two samples on
  sequence s_wr(logic [HPVR_AW-1:0] a);
    regWrite && regAddr == a;
  endsequence
  // ==========================================================
  // Assertions
  a_vid_copy: assert property (
    s_wr(HPVR_OFF_TAG) |-> ##2 defaultVid_q == $past(regWrData[11:0], 2))
    else $error("default vid copy wrong");
  a_prio_copy: assert property (
    s_wr(HPVR_OFF_TAG) |-> ##2 {defaultPriority_q, defaultCfi_q} == $past(regWrData[15:12], 2))
    else $error("default priority copy wrong");
  a_edge_copy: assert property (
    s_wr(HPVR_OFF_IRLO) |-> ##2 rmiiSampleFalling_q == $past(regWrData[7], 2))
    else $error("sample edge copy wrong");
  a_queue_copy: assert property (
    s_wr(HPVR_OFF_QCFG) |-> ##2 multiQueue_q == $past(regWrData[0], 2))
    else $error("queue select copy wrong");
  a_strap_load: assert property (
    $fell(srst) |-> ##2 macMiiMode_q == $past(rxDataValidPin, 4))
    else $error("strap not captured");
  a_ig_answer: assert property (igDone_q == $past(igFrame))
    else $error("ingress answer timing wrong");
  a_eg_answer: assert property (egDone_q == $past(egFrame))
    else $error("egress answer timing wrong");
  a_single_queue: assert property (egDone_q && !multiQueue_q |-> egQueue_q == 2'h0)
    else $error("single queue not used");
endmodule : hpvr_checker
`default_nettype wire

// ==== verification/hpvr_host_model.sv ====
// Host-side MAC model: receive-valid strap level and ingress frames
`default_nettype none
module hpvr_host_model (
  input wire logic clock,
  output logic rxDataValidPin,
  output logic igFrame,
  output logic [hpvr_pkg::HPVR_LEN_W-1:0] igLength,
  output logic [1:0] igPriority,
  output logic igBroadcast,
  output logic igMulticast,
  output logic igFloodUnicast
);
  timeunit 1ns;
  timeprecision 1ns;
  import hpvr_pkg::*;
  initial begin
    rxDataValidPin = 1'b1;
    {igFrame, igLength, igPriority, igBroadcast, igMulticast, igFloodUnicast} = '0;
  end
  // Qualifiers flip outside frames so stale values cannot pass for a match
  task automatic send(input logic [HPVR_LEN_W-1:0] len, input logic [1:0] pri,
                      input logic [2:0] cls);
    @(posedge clock);
    igFrame <= 1'b1;
    {igLength, igPriority, igBroadcast, igMulticast, igFloodUnicast} <= {len, pri, cls};
    @(posedge clock);
    igFrame <= 1'b0;
    {igLength, igPriority, igBroadcast, igMulticast, igFloodUnicast} <= ~{len, pri, cls};
  endtask : send
  task automatic strap(input logic v);
    rxDataValidPin <= v;
  endtask : strap
endmodule : hpvr_host_model
`default_nettype wire

// ==== verification/tb_host_port_vlan_rate_control.sv ====
// Self-checking bench for the host port VLAN and rate control block
`default_nettype none
module tb_host_port_vlan_rate_control;
  timeunit 1ns;
  timeprecision 1ns;
  import hpvr_pkg::*;
  // Nibble-padded fields: mode, rate low, rate high or queue config,
  // egress, length, priority, class {b,m,f}, refused
  typedef struct packed {
    logic [7:0] mode;
    logic [15:0] rlo;
    logic [15:0] rhi;
    logic [3:0] eg;
    logic [11:0] len;
    logic [3:0] pri;
    logic [3:0] cls;
    logic [3:0] hit;
  } hpvr_row_s;
  hpvr_row_s rows [19] = '{
    68'h00_0001_0000_0_062_0_0_0, 68'h02_0001_0000_0_057_0_0_1,
    68'h01_0001_0000_0_05b_0_0_1, 68'h04_0001_0000_0_0c8_0_0_0,
    68'h04_0001_0000_0_0c8_0_1_1, 68'h08_0001_0000_0_0c8_0_1_0,
    68'h08_0001_0000_0_0c8_0_2_1, 68'h0c_0001_0000_0_0c8_0_2_0,
    68'h0c_0001_0000_0_0c8_0_4_1, 68'h00_0100_0000_0_0c8_1_0_1,
    68'h00_0100_0000_0_0c8_0_0_0, 68'h00_0000_0302_0_0c4_2_0_0,
    68'h00_0000_0302_0_127_3_0_1, 68'h00_0001_0000_1_0c8_2_0_0,
    68'h00_0081_0000_1_0c8_2_0_1, 68'h00_0180_0000_1_0c8_1_0_0,
    68'h00_0180_0003_1_0c8_2_0_1, 68'h00_0180_0003_1_0c8_0_0_0,
    68'h00_0080_0001_1_0c8_3_0_1};
  logic [HPVR_AW-1:0] zeroRegs [6] = '{HPVR_OFF_IRLO, HPVR_OFF_IRHI, HPVR_OFF_ERLO,
    HPVR_OFF_ERHI, HPVR_OFF_QCFG, 8'hfe};
  logic clock = 1'b0, srst = 1'b1, regWrite = 1'b0, regRead = 1'b0, egFrame = 1'b0;
  logic [HPVR_AW-1:0] regAddr = '0;
  logic [HPVR_DW-1:0] regWrData = '0;
  logic [HPVR_LEN_W-1:0] egLength = '0;
  logic [1:0] egPriority = '0;
  logic [HPVR_DW-1:0] regRdData_q;
  logic [HPVR_LEN_W-1:0] igLength;
  logic [1:0] igPriority, egQueue_q;
  logic [HPVR_VID_W-1:0] defaultVid_q;
  logic [HPVR_UPRI_W-1:0] defaultPriority_q;
  logic rxDataValidPin, igFrame, igBroadcast, igMulticast, igFloodUnicast, igDone_q, igDrop_q;
  logic egDone_q, egAllow_q, defaultCfi_q, macMiiMode_q, rmiiSampleFalling_q, multiQueue_q;
  int errorCnt = 0, compares = 0, cycleCnt = 0;

  hpvr_host_port_ctrl #(.WINDOW_CYC(64)) hpvr_host_port_ctrl_inst (
    .clock, .srst, .regAddr, .regWrData, .regWrite, .regRead, .regRdData_q, .rxDataValidPin,
    .igFrame, .igLength, .igPriority, .igBroadcast, .igMulticast, .igFloodUnicast, .igDone_q,
    .igDrop_q, .egFrame, .egLength, .egPriority, .egDone_q, .egAllow_q, .egQueue_q,
    .defaultVid_q, .defaultPriority_q, .defaultCfi_q, .macMiiMode_q, .rmiiSampleFalling_q,
    .multiQueue_q);
  hpvr_host_model hpvr_host_model_inst (.clock, .rxDataValidPin, .igFrame, .igLength,
    .igPriority, .igBroadcast, .igMulticast, .igFloodUnicast);

  always #10 clock = ~clock;
  always @(posedge clock) begin
    cycleCnt <= cycleCnt + 1;
    if (cycleCnt == 4000) begin
      errorCnt++;
      tally_and_finish();
    end
  end
  // ==========================================================
  // Bus and compare tasks
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    compares++;
    if (got !== exp) begin
      errorCnt++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic wr(input logic [HPVR_AW-1:0] a, input logic [HPVR_DW-1:0] d);
    @(posedge clock);
    {regWrite, regAddr, regWrData} <= {1'b1, a, d};
    @(posedge clock);
    regWrite <= 1'b0;
  endtask : wr
  task automatic rd(input logic [HPVR_AW-1:0] a, input logic [HPVR_DW-1:0] exp);
    @(posedge clock);
    {regRead, regAddr} <= {1'b1, a};
    @(posedge clock);
    regRead <= 1'b0;
    #1 chk(regRdData_q, exp);
  endtask : rd
  // Each row waits out a full metering window so its bucket starts empty
  task automatic run_row(input hpvr_row_s r);
    logic [1:0] q;
    q = !r.rhi[0] ? 2'h0 : r.rhi[1] ? {1'b0, r.pri[1:0] != 2'h0} : r.pri[1:0];
    wr(HPVR_OFF_MODE, {8'h00, r.mode});
    wr(r.eg[0] ? HPVR_OFF_ERLO : HPVR_OFF_IRLO, r.rlo);
    wr(r.eg[0] ? HPVR_OFF_QCFG : HPVR_OFF_IRHI, r.rhi);
    repeat (70) @(posedge clock);
    if (r.eg[0]) begin
      @(posedge clock);
      {egFrame, egLength, egPriority} <= {1'b1, r.len[10:0], r.pri[1:0]};
      @(posedge clock);
      {egFrame, egLength, egPriority} <= {1'b0, ~r.len[10:0], ~r.pri[1:0]};
      #1 chk({egDone_q, egAllow_q, egQueue_q}, {1'b1, ~r.hit[0], q});
    end else begin
      hpvr_host_model_inst.send(r.len[10:0], r.pri[1:0], r.cls[2:0]);
      #1 chk({igDone_q, igDrop_q}, {1'b1, r.hit[0]});
    end
  endtask : run_row
  task automatic tally_and_finish();
    $display("mismatches %0d, comparisons %0d", errorCnt, compares);
    if (errorCnt == 0 && compares > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : tally_and_finish
  // ==========================================================
  // Main sequence
  initial begin
    repeat (8) @(posedge clock);
    srst <= 1'b0;
    @(posedge clock);
    rd(HPVR_OFF_TAG, 16'h0001);
    rd(HPVR_OFF_MODE, 16'h0080);
    foreach (zeroRegs[i]) rd(zeroRegs[i], 16'h0000);
    chk({defaultPriority_q, defaultCfi_q, defaultVid_q}, 16'h0001);
    chk({macMiiMode_q, rmiiSampleFalling_q, multiQueue_q}, 3'h4);
    wr(HPVR_OFF_TAG, 16'hffff);
    wr(8'hfe, 16'h1234);
    rd(HPVR_OFF_TAG, 16'hffff);
    chk({defaultPriority_q, defaultCfi_q, defaultVid_q}, 16'hffff);
    wr(HPVR_OFF_IRLO, 16'hffff);
    rd(HPVR_OFF_IRLO, 16'h7fff);
    chk(rmiiSampleFalling_q, 1'b1);
    wr(HPVR_OFF_IRHI, 16'hffff);
    rd(HPVR_OFF_IRHI, 16'h7f7f);
    wr(HPVR_OFF_ERHI, 16'h0100);
    foreach (rows[i]) run_row(rows[i]);
    rd(HPVR_OFF_STAT, 16'h0307);
    @(posedge clock);
    hpvr_host_model_inst.strap(1'b0);
    srst <= 1'b1;
    repeat (8) @(posedge clock);
    srst <= 1'b0;
    @(posedge clock);
    rd(HPVR_OFF_MODE, 16'h0000);
    wr(HPVR_OFF_MODE, 16'h0080);
    rd(HPVR_OFF_MODE, 16'h0080);
    chk(macMiiMode_q, 1'b1);
    rd(HPVR_OFF_STAT, 16'h0000);
    // Window phase is known after reset: two frames share a bucket, a later window is empty
    wr(HPVR_OFF_IRLO, 16'h0001);
    hpvr_host_model_inst.send(11'h03c, 2'h0, 3'h0);
    #1 chk({igDone_q, igDrop_q}, 2'b10);
    hpvr_host_model_inst.send(11'h03c, 2'h0, 3'h0);
    #1 chk({igDone_q, igDrop_q}, 2'b11);
    repeat (64) @(posedge clock);
    hpvr_host_model_inst.send(11'h03c, 2'h0, 3'h0);
    #1 chk({igDone_q, igDrop_q}, 2'b10);
    rd(HPVR_OFF_STAT, 16'h0001);
    tally_and_finish();
  end
endmodule : tb_host_port_vlan_rate_control

bind hpvr_host_port_ctrl hpvr_checker hpvr_checker_inst (.clock, .srst, .regAddr, .regWrData,
  .regWrite, .rxDataValidPin, .igFrame, .igDone_q, .egFrame, .egDone_q, .egQueue_q,
  .defaultVid_q, .defaultPriority_q, .defaultCfi_q, .macMiiMode_q, .rmiiSampleFalling_q,
  .multiQueue_q);
`default_nettype wire
